// ---- design/kpic_pkg.sv ----
// Constants shared by the keying and panel input control block
package kpic_pkg;
  // Clock and timing figures in their own units
  localparam int CLK_HZ = 20_000_000;
  localparam int HOLD_MS = 10;
  localparam int DEB_US = 5000;
  localparam int BAUD = 9600;
  localparam int PRACT_MS = 2000;
  localparam int MS_CYCLES_DEF = CLK_HZ / 1000;
  localparam int HOLD_CYCLES_DEF = (CLK_HZ / 1000) * HOLD_MS;
  localparam int DEB_CYCLES_DEF = (CLK_HZ / 1_000_000) * DEB_US;
  localparam int PRACT_CYCLES_DEF = (CLK_HZ / 1000) * PRACT_MS;
  localparam int BIT_CYCLES = CLK_HZ / BAUD;
  localparam int HALF_BIT_CYCLES = BIT_CYCLES / 2;

  // Keyer speed: dot milliseconds = DOT_NUM / wpm
  localparam logic [10:0] DOT_NUM = 11'h4b0;
  localparam logic [7:0] WPM_RST = 8'h18;
  localparam logic [7:0] WPM_MIN = 8'h01;
  localparam logic [1:0] DASH_UNITS = 2'h3;
  localparam logic [1:0] DOT_UNITS = 2'h1;

  // Button ladder: 10-bit codes, thresholds midway between nominals
  localparam int ADC_W = 10;
  localparam logic [2:0] ADC_BTN_CH = 3'h3;
  localparam logic [9:0] TH_SELECT = 10'h181;
  localparam logic [9:0] TH_EXIT = 10'h352;
  localparam logic [9:0] TH_SHAFT = 10'h3d1;
  localparam logic [1:0] BTN_NONE = 2'h0;
  localparam logic [1:0] BTN_SELECT = 2'h1;
  localparam logic [1:0] BTN_EXIT = 2'h2;
  localparam logic [1:0] BTN_SHAFT = 2'h3;

  // Operating modes
  localparam logic [1:0] MODE_STRAIGHT = 2'h0;
  localparam logic [1:0] MODE_IAMBIC = 2'h1;
  localparam logic [1:0] MODE_BEACON = 2'h2;

  // Register map
  localparam int AW = 3;
  localparam int DW = 16;
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_SPEED = 3'h1;
  localparam logic [2:0] REG_BEACON = 3'h2;
  localparam logic [2:0] REG_STATUS = 3'h3;
  localparam logic [2:0] REG_ENCODER = 3'h4;
  localparam logic [2:0] REG_GPS_DATA = 3'h5;
  localparam logic [2:0] REG_DOT_MS = 3'h6;
  localparam int CTRL_PRACT_BIT = 2;

  // Status field positions
  localparam int ST_BTN_EVT = 2;
  localparam int ST_PPS_EVT = 3;
  localparam int ST_SER_EVT = 4;
  localparam int ST_FORCED = 5;
  localparam int ST_KEY = 6;
  localparam int ST_RX = 7;
endpackage

// ---- design/kpic_debounce.sv ----
// Edge-accepting lockout debouncer for a group of switch inputs
`timescale 1ns/1ps
module kpic_debounce #(
  parameter int WIDTH = 2,
  parameter int LOCK_CYCLES = 100000,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] raw,
  output logic [WIDTH-1:0] clean
);
  localparam int CW = $clog2(LOCK_CYCLES + 1);
  localparam logic [CW-1:0] LOCK_MAX = CW'(LOCK_CYCLES);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic [CW-1:0] lock_reg;
      // First edge passes at once, then bounce is ignored for the lockout
      always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          clean[i] <= INIT[i];
          lock_reg <= '0;
        end else if (lock_reg != '0) begin
          lock_reg <= lock_reg - 1'b1;
        end else if (raw[i] != clean[i]) begin
          clean[i] <= raw[i];
          lock_reg <= LOCK_MAX;
        end
      end
    end
  endgenerate
endmodule // kpic_debounce

// ---- design/kpic_serial_rx.sv ----
// Asynchronous 8N1 serial receiver built from logic
`timescale 1ns/1ps
module kpic_serial_rx
  import kpic_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic rxd,
  output logic [7:0] data,
  output logic valid
);
  typedef enum logic [1:0] {SR_IDLE, SR_START, SR_DATA, SR_STOP} kpic_sr_t;
  localparam logic [11:0] BIT_MAX = 12'(BIT_CYCLES - 1);
  localparam logic [11:0] HALF_MAX = 12'(HALF_BIT_CYCLES - 1);

  kpic_sr_t state_reg;
  logic [11:0] cnt_reg;
  logic [2:0] bit_reg;
  logic [7:0] shift_reg;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg <= SR_IDLE;
      cnt_reg <= '0;
      bit_reg <= '0;
      shift_reg <= '0;
      data <= '0;
      valid <= 1'b0;
    end else begin
      valid <= 1'b0;
      if (cnt_reg != '0) begin
        cnt_reg <= cnt_reg - 1'b1;
      end else begin
        unique case (state_reg)
          SR_IDLE: begin
            if (!rxd) begin
              state_reg <= SR_START;
              cnt_reg <= HALF_MAX;
            end
          end
          SR_START: begin
            // Recheck mid start bit so a glitch is not taken as a frame
            state_reg <= rxd ? SR_IDLE : SR_DATA;
            cnt_reg <= BIT_MAX;
            bit_reg <= '0;
          end
          SR_DATA: begin
            shift_reg <= {rxd, shift_reg[7:1]};
            cnt_reg <= BIT_MAX;
            bit_reg <= bit_reg + 1'b1;
            if (bit_reg == 3'h7) begin
              state_reg <= SR_STOP;
            end
          end
          SR_STOP: begin
            state_reg <= SR_IDLE;
            if (rxd) begin
              data <= shift_reg;
              valid <= 1'b1;
            end
          end
        endcase
      end
    end
  end
endmodule // kpic_serial_rx

// ---- design/kpic_top.sv ----
// Keying, TX/RX sequencing and panel input control
// Summary of operation
// - Straight mode: key output follows the key input with no added timing.
// - Iambic and beacon modes: keyer generates timed dot and dash elements.
// - After key-up, wait 10 ms before returning from transmit to receive.
// - Receive enable high in receive, low in transmit and the hold.
// - Transmit mute is always the inverse of receive enable.
// - Quadrature encoder decoded by state machine, giving steps and direction.
// - Every mechanical switch input is debounced in logic.
// - Internal pull-ups enabled on the switch inputs.
// - No internal pull-up on the shared button input.
// - Button press seen as rise on shared input, then channel 3 sampled.
// - Sample level identifies none, select, shaft or exit button.
// - Analogue samples are 10-bit codes spanning zero to five volts.
// - GPS serial data at 9600 baud received by logic on a paddle input.
// - Serial data on the paddle input forces practice mode and indicator.
`timescale 1ns/1ps
module kpic_top
  import kpic_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEF,
  parameter int HOLD_CYCLES = HOLD_CYCLES_DEF,
  parameter int DEB_CYCLES = DEB_CYCLES_DEF,
  parameter int PRACT_CYCLES = PRACT_CYCLES_DEF
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [DW-1:0] rdata,
  input wire logic dit_in_n,
  input wire logic dah_in_n,
  input wire logic enc_a_n,
  input wire logic enc_b_n,
  input wire logic button_level,
  output logic adc_start,
  output logic [2:0] adc_channel,
  input wire logic [ADC_W-1:0] adc_data,
  input wire logic adc_valid,
  output logic switch_pullup_en,
  output logic button_pullup_en,
  output logic key_out,
  output logic rx_enable,
  output logic tx_mute,
  output logic practice_ind
);
  typedef enum logic [1:0] {K_IDLE, K_MARK, K_SPACE} kpic_key_t;
  typedef enum logic [2:0] {
    E_REST, E_CW1, E_CW2, E_CW3, E_CCW1, E_CCW2, E_CCW3
  } kpic_enc_t;

  localparam int MW = $clog2(MS_CYCLES + 1);
  localparam int HW = $clog2(HOLD_CYCLES + 1);
  localparam int PW = $clog2(PRACT_CYCLES + 1);

  function automatic logic [1:0] kpic_classify(input logic [9:0] code);
    if (code >= TH_SHAFT) return BTN_SHAFT;
    else if (code >= TH_EXIT) return BTN_EXIT;
    else if (code >= TH_SELECT) return BTN_SELECT;
    else return BTN_NONE;
  endfunction

  function automatic logic kpic_wr(input logic [AW-1:0] a,
                                   input logic [AW-1:0] r,
                                   input logic s);
    return s && (a == r);
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Pins and debouncing
  assign switch_pullup_en = 1'b1;
  assign button_pullup_en = 1'b0;
  assign adc_channel = ADC_BTN_CH;

  logic [4:0] sw_clean;
  kpic_debounce #(
    .WIDTH(5),
    .LOCK_CYCLES(DEB_CYCLES),
    .INIT(5'h0f)
  ) u_deb (
    .clock(clock),
    .nrst(nrst),
    .raw({button_level, enc_b_n, enc_a_n, dah_in_n, dit_in_n}),
    .clean(sw_clean)
  );

  logic dit_on, dah_on, btn_lvl;
  logic [1:0] enc_ab;
  assign dit_on = ~sw_clean[0];
  assign dah_on = ~sw_clean[1];
  assign enc_ab = ~sw_clean[3:2];
  assign btn_lvl = sw_clean[4];

  //////////////////////////////////////////////////////////////////////
  // Registers written by software
  logic [1:0] mode_reg;
  logic pract_sw_reg;
  logic [7:0] wpm_reg;
  logic beacon_pend_reg, beacon_dash_reg;
  logic [10:0] dot_ms_reg, div_rem_reg, div_q_reg;
  logic div_busy_reg;
  logic key_start;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mode_reg <= MODE_STRAIGHT;
      pract_sw_reg <= 1'b0;
    end else if (kpic_wr(addr, REG_CTRL, wr_stb)) begin
      mode_reg <= wdata[1:0];
      pract_sw_reg <= wdata[CTRL_PRACT_BIT];
    end
  end

  // Dot length by repeated subtraction after each speed change
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wpm_reg <= WPM_RST;
      div_busy_reg <= 1'b1;
      div_rem_reg <= DOT_NUM;
      div_q_reg <= '0;
      dot_ms_reg <= '0;
    end else if (kpic_wr(addr, REG_SPEED, wr_stb)) begin
      wpm_reg <= (wdata[7:0] < WPM_MIN) ? WPM_MIN : wdata[7:0];
      div_busy_reg <= 1'b1;
      div_rem_reg <= DOT_NUM;
      div_q_reg <= '0;
    end else if (div_busy_reg) begin
      if (div_rem_reg >= {3'h0, wpm_reg}) begin
        div_rem_reg <= div_rem_reg - {3'h0, wpm_reg};
        div_q_reg <= div_q_reg + 1'b1;
      end else begin
        dot_ms_reg <= div_q_reg;
        div_busy_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      beacon_pend_reg <= 1'b0;
      beacon_dash_reg <= 1'b0;
    end else if (kpic_wr(addr, REG_BEACON, wr_stb)) begin
      beacon_pend_reg <= 1'b1;
      beacon_dash_reg <= wdata[0];
    end else if (key_start && mode_reg == MODE_BEACON) begin
      beacon_pend_reg <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Element keyer for iambic and beacon modes
  kpic_key_t key_state_reg;
  logic [MW-1:0] pre_reg;
  logic [10:0] ms_reg;
  logic [1:0] units_reg;
  logic last_dash_reg, dit_mem_reg, dah_mem_reg;
  logic want, want_dash, unit_tick;

  always_comb begin
    want = 1'b0;
    want_dash = 1'b0;
    if (mode_reg == MODE_BEACON) begin
      want = beacon_pend_reg;
      want_dash = beacon_dash_reg;
    end else if (mode_reg == MODE_IAMBIC) begin
      want = dit_on | dah_on | dit_mem_reg | dah_mem_reg;
      if ((dit_on | dit_mem_reg) && (dah_on | dah_mem_reg)) begin
        want_dash = ~last_dash_reg;
      end else begin
        want_dash = dah_on | dah_mem_reg;
      end
    end
  end

  assign key_start = (key_state_reg == K_IDLE) && want && !div_busy_reg;
  assign unit_tick = (pre_reg == MW'(MS_CYCLES - 1))
                     && (ms_reg + 1'b1 >= dot_ms_reg);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      key_state_reg <= K_IDLE;
      pre_reg <= '0;
      ms_reg <= '0;
      units_reg <= '0;
      last_dash_reg <= 1'b0;
    end else begin
      if (key_state_reg == K_IDLE || pre_reg == MW'(MS_CYCLES - 1)) begin
        pre_reg <= '0;
      end else begin
        pre_reg <= pre_reg + 1'b1;
      end
      if (key_state_reg == K_IDLE || unit_tick) begin
        ms_reg <= '0;
      end else if (pre_reg == MW'(MS_CYCLES - 1)) begin
        ms_reg <= ms_reg + 1'b1;
      end
      unique case (key_state_reg)
        K_IDLE: begin
          if (key_start) begin
            key_state_reg <= K_MARK;
            units_reg <= want_dash ? DASH_UNITS : DOT_UNITS;
            last_dash_reg <= want_dash;
          end
        end
        K_MARK: begin
          if (unit_tick) begin
            units_reg <= units_reg - 1'b1;
            if (units_reg == DOT_UNITS) begin
              key_state_reg <= K_SPACE;
              units_reg <= DOT_UNITS;
            end
          end
        end
        K_SPACE: begin
          if (unit_tick) begin
            key_state_reg <= K_IDLE;
          end
        end
      endcase
    end
  end

  // Opposite paddle pressed during an element is remembered
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      dit_mem_reg <= 1'b0;
      dah_mem_reg <= 1'b0;
    end else if (key_start) begin
      dit_mem_reg <= 1'b0;
      dah_mem_reg <= 1'b0;
    end else if (key_state_reg != K_IDLE && mode_reg == MODE_IAMBIC) begin
      dit_mem_reg <= dit_mem_reg | (dit_on & last_dash_reg);
      dah_mem_reg <= dah_mem_reg | (dah_on & ~last_dash_reg);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // GPS serial, second pulse and forced practice
  logic [7:0] ser_data, gps_byte_reg;
  logic ser_valid, forced_reg, dit_on_d_reg, pps_rise;
  logic [PW-1:0] pract_cnt_reg;

  kpic_serial_rx u_rx (
    .clock(clock),
    .nrst(nrst),
    .rxd(dah_in_n),
    .data(ser_data),
    .valid(ser_valid)
  );

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      forced_reg <= 1'b0;
      pract_cnt_reg <= '0;
      gps_byte_reg <= '0;
      dit_on_d_reg <= 1'b0;
    end else begin
      dit_on_d_reg <= dit_on;
      if (ser_valid) begin
        gps_byte_reg <= ser_data;
        forced_reg <= 1'b1;
        pract_cnt_reg <= PW'(PRACT_CYCLES);
      end else if (pract_cnt_reg != '0) begin
        pract_cnt_reg <= pract_cnt_reg - 1'b1;
      end else begin
        forced_reg <= 1'b0;
      end
    end
  end
  // High pin level on the dot line is the positive-going second pulse
  assign pps_rise = dit_on_d_reg & ~dit_on;

  //////////////////////////////////////////////////////////////////////
  // Key output and TX/RX sequencing
  logic practice, key_next;
  logic [HW-1:0] hold_reg;
  assign practice = pract_sw_reg | forced_reg;

  always_comb begin
    if (practice) begin
      key_next = 1'b0;
    end else if (mode_reg == MODE_STRAIGHT) begin
      key_next = dit_on;
    end else begin
      key_next = (key_state_reg == K_MARK);
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      key_out <= 1'b0;
      hold_reg <= '0;
      rx_enable <= 1'b1;
      practice_ind <= 1'b0;
    end else begin
      key_out <= key_next;
      practice_ind <= practice;
      if (key_next) begin
        hold_reg <= HW'(HOLD_CYCLES);
      end else if (hold_reg != '0) begin
        hold_reg <= hold_reg - 1'b1;
      end
      rx_enable <= ~key_next && (hold_reg <= HW'(1));
    end
  end
  assign tx_mute = ~rx_enable;

  //////////////////////////////////////////////////////////////////////
  // Quadrature encoder
  kpic_enc_t enc_reg;
  logic [7:0] enc_cnt_reg;
  logic enc_dir_reg;

  // Full detent cycle 00-01-11-10-00; bounce steps back without counting
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      enc_reg <= E_REST;
      enc_cnt_reg <= '0;
      enc_dir_reg <= 1'b0;
    end else begin
      unique case (enc_reg)
        E_REST: if (enc_ab == 2'h1) enc_reg <= E_CW1;
                else if (enc_ab == 2'h2) enc_reg <= E_CCW1;
        E_CW1: if (enc_ab == 2'h3) enc_reg <= E_CW2;
               else if (enc_ab == 2'h0) enc_reg <= E_REST;
        E_CW2: if (enc_ab == 2'h2) enc_reg <= E_CW3;
               else if (enc_ab == 2'h1) enc_reg <= E_CW1;
        E_CW3: begin
          if (enc_ab == 2'h0) begin
            enc_reg <= E_REST;
            enc_cnt_reg <= enc_cnt_reg + 1'b1;
            enc_dir_reg <= 1'b1;
          end else if (enc_ab == 2'h3) enc_reg <= E_CW2;
        end
        E_CCW1: if (enc_ab == 2'h3) enc_reg <= E_CCW2;
                else if (enc_ab == 2'h0) enc_reg <= E_REST;
        E_CCW2: if (enc_ab == 2'h1) enc_reg <= E_CCW3;
                else if (enc_ab == 2'h2) enc_reg <= E_CCW1;
        E_CCW3: begin
          if (enc_ab == 2'h0) begin
            enc_reg <= E_REST;
            enc_cnt_reg <= enc_cnt_reg - 1'b1;
            enc_dir_reg <= 1'b0;
          end else if (enc_ab == 2'h3) enc_reg <= E_CCW2;
        end
        default: enc_reg <= E_REST;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Button ladder
  logic btn_d_reg;
  logic [1:0] btn_id_reg;
  logic btn_evt_reg, pps_evt_reg, ser_evt_reg, st_clr;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      btn_d_reg <= 1'b0;
      adc_start <= 1'b0;
      btn_id_reg <= BTN_NONE;
    end else begin
      btn_d_reg <= btn_lvl;
      adc_start <= btn_lvl & ~btn_d_reg;
      if (adc_valid) begin
        btn_id_reg <= kpic_classify(adc_data);
      end
    end
  end

  // Status events: reading clears, a new event in that cycle wins
  assign st_clr = rd_stb && (addr == REG_STATUS);
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      btn_evt_reg <= 1'b0;
      pps_evt_reg <= 1'b0;
      ser_evt_reg <= 1'b0;
    end else begin
      btn_evt_reg <= adc_valid | (btn_evt_reg & ~st_clr);
      pps_evt_reg <= pps_rise | (pps_evt_reg & ~st_clr);
      ser_evt_reg <= ser_valid | (ser_evt_reg & ~st_clr);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Read port
  logic [DW-1:0] status_word;
  always_comb begin
    status_word = '0;
    status_word[1:0] = btn_id_reg;
    status_word[ST_BTN_EVT] = btn_evt_reg;
    status_word[ST_PPS_EVT] = pps_evt_reg;
    status_word[ST_SER_EVT] = ser_evt_reg;
    status_word[ST_FORCED] = forced_reg;
    status_word[ST_KEY] = key_out;
    status_word[ST_RX] = rx_enable;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdata <= '0;
    end else if (rd_stb) begin
      unique case (addr)
        REG_CTRL: rdata <= {13'h0, pract_sw_reg, mode_reg};
        REG_SPEED: rdata <= {8'h0, wpm_reg};
        REG_BEACON: rdata <= {14'h0, key_state_reg != K_IDLE,
                              beacon_pend_reg};
        REG_STATUS: rdata <= status_word;
        REG_ENCODER: rdata <= {7'h0, enc_dir_reg, enc_cnt_reg};
        REG_GPS_DATA: rdata <= {8'h0, gps_byte_reg};
        REG_DOT_MS: rdata <= {5'h0, dot_ms_reg};
        default: rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end
endmodule // kpic_top

// ---- testbench/kpic_sva.sv ----
// Assertion checker for the keying block
`timescale 1ns/1ps
module kpic_sva
  import kpic_pkg::*;
#(
  parameter int MS_CYCLES = 20,
  parameter int HOLD_CYCLES = 200
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [DW-1:0] rdata,
  input wire logic dit_in_n,
  input wire logic button_level,
  input wire logic adc_start,
  input wire logic [2:0] adc_channel,
  input wire logic switch_pullup_en,
  input wire logic button_pullup_en,
  input wire logic key_out,
  input wire logic rx_enable,
  input wire logic tx_mute,
  input wire logic practice_ind
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  logic [1:0] mode_reg;
  logic [7:0] wpm_reg;
  int lo_cnt, hi_cnt, unit;
  assign unit = (1200 / int'(wpm_reg)) * MS_CYCLES;
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mode_reg <= MODE_STRAIGHT;
      wpm_reg <= WPM_RST;
    end else if (wr_stb && addr == REG_CTRL) begin
      mode_reg <= wdata[1:0];
    end else if (wr_stb && addr == REG_SPEED) begin
      wpm_reg <= (wdata[7:0] == 8'h00) ? WPM_MIN : wdata[7:0];
    end
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      lo_cnt <= HOLD_CYCLES + 9;
      hi_cnt <= 0;
    end else begin
      lo_cnt <= key_out ? 0 : (lo_cnt > HOLD_CYCLES + 8 ? lo_cnt : lo_cnt + 1);
      hi_cnt <= key_out ? hi_cnt + 1 : 0;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  sequence s_dit_down;
    mode_reg == MODE_STRAIGHT && !practice_ind ##0 $fell(dit_in_n);
  endsequence
  sequence s_key_on;
    ##2 key_out;
  endsequence
  a_straight_follow: assert property (s_dit_down |-> s_key_on)
    else $error("straight key lost");
  a_element_len: assert property ($fell(key_out) && mode_reg == MODE_IAMBIC
    |-> hi_cnt == unit || hi_cnt == 3 * unit)
    else $error("element length");
  a_rx_hold: assert property (!practice_ind && lo_cnt < HOLD_CYCLES - 3
    |-> !rx_enable) else $error("rx early");
  a_rx_return: assert property (lo_cnt == HOLD_CYCLES + 3 |-> rx_enable)
    else $error("rx late");
  a_rx_keyed: assert property (key_out |-> !rx_enable)
    else $error("rx while keyed");
  a_mute_inverse: assert property (tx_mute == !rx_enable)
    else $error("mute not inverse");
  a_pullup_set: assert property (switch_pullup_en && !button_pullup_en)
    else $error("pull-ups");
  a_btn_sample: assert property ($rose(button_level)
    |-> ##[1:3] adc_start && adc_channel == ADC_BTN_CH)
    else $error("no conversion");
  a_practice_key: assert property (practice_ind [*3] |-> !key_out)
    else $error("keyed in practice");
  a_read_idle: assert property (!$past(rd_stb) |-> rdata == '0)
    else $error("stray read data");
endmodule // kpic_sva
bind kpic_top kpic_sva #(.MS_CYCLES(MS_CYCLES), .HOLD_CYCLES(HOLD_CYCLES))
  kpic_sva_i (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata),
  .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .dit_in_n(dit_in_n),
  .button_level(button_level), .adc_start(adc_start),
  .adc_channel(adc_channel), .switch_pullup_en(switch_pullup_en),
  .button_pullup_en(button_pullup_en), .key_out(key_out),
  .rx_enable(rx_enable), .tx_mute(tx_mute), .practice_ind(practice_ind));

// ---- testbench/kpic_panel_model.sv ----
// Front panel button ladder and converter model
`timescale 1ns/1ps
module kpic_panel_model
  import kpic_pkg::*;
(
  input wire logic clock,
  input wire logic [1:0] btn,
  input wire logic adc_start,
  output logic button_level,
  output logic [ADC_W-1:0] adc_data,
  output logic adc_valid
);
  logic [2:0] wait_reg = 3'h0;
  int mv;
  always_comb begin
    case (btn)
      BTN_SELECT: mv = 3760;
      BTN_EXIT: mv = 4550;
      BTN_SHAFT: mv = 5000;
      default: mv = 0;
    endcase
  end
  // Pull-down holds the line low when idle
  assign button_level = (btn != BTN_NONE);
  ////////////////////////////////////////////////////////////////////////
  // Result three cycles on, junk data between
  initial adc_data = '0;
  initial adc_valid = 1'b0;
  always @(posedge clock) begin
    adc_valid <= 1'b0;
    adc_data <= ~adc_data;
    if (adc_start) begin
      wait_reg <= 3'h3;
    end else if (wait_reg != 3'h0) begin
      wait_reg <= wait_reg - 3'h1;
      if (wait_reg == 3'h1) begin
        adc_valid <= 1'b1;
        adc_data <= 10'((mv * 1023) / 5000);
      end
    end
  end
endmodule // kpic_panel_model

// ---- testbench/tb.sv ----
// Self-checking bench for the keying block
`timescale 1ns/1ps
module tb;
  import kpic_pkg::*;
  localparam int HOLD = 200;
  logic clock = 1'b0, nrst = 1'b0;
  logic [AW-1:0] addr = '0;
  logic [DW-1:0] wdata = '0;
  logic wr_stb = 1'b0, rd_stb = 1'b0;
  logic dit_in_n = 1'b1, dah_in_n = 1'b1, enc_a_n = 1'b1, enc_b_n = 1'b1;
  logic [1:0] btn = BTN_NONE;
  logic [DW-1:0] rdata;
  logic [DW-1:0] got;
  logic button_level, adc_start, adc_valid, key_out, rx_enable, tx_mute;
  logic practice_ind, sw_pu, btn_pu;
  logic [2:0] adc_channel;
  logic [ADC_W-1:0] adc_data;
  logic [31:0] seed = 32'h00014fc6;
  logic [7:0] byte_v;
  int fail_count = 0, checks_done = 0;
  int n, wpm, lo_n = 0, run = 0, last_run = 0;
  always #25 clock = ~clock;
  kpic_top #(.MS_CYCLES(20), .HOLD_CYCLES(HOLD), .DEB_CYCLES(5),
    .PRACT_CYCLES(2000)) kpic_top_i (.clock(clock), .nrst(nrst),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .dit_in_n(dit_in_n), .dah_in_n(dah_in_n),
    .enc_a_n(enc_a_n), .enc_b_n(enc_b_n), .button_level(button_level),
    .adc_start(adc_start), .adc_channel(adc_channel), .adc_data(adc_data),
    .adc_valid(adc_valid), .switch_pullup_en(sw_pu),
    .button_pullup_en(btn_pu), .key_out(key_out), .rx_enable(rx_enable),
    .tx_mute(tx_mute), .practice_ind(practice_ind));
  kpic_panel_model kpic_panel_model_i (.clock(clock), .btn(btn),
    .adc_start(adc_start), .button_level(button_level),
    .adc_data(adc_data), .adc_valid(adc_valid));
  ////////////////////////////////////////////////////////////////////////
  // Reference: key-up cycles and last key-down length
  always @(posedge clock) begin
    lo_n <= key_out ? 0 : lo_n + 1;
    run <= key_out ? run + 1 : 0;
    if (!key_out && run != 0) last_run <= run;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [DW-1:0] g, e);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1 d = rdata;
    @(posedge clock);
  endtask
  task automatic wt(input bit rx, input logic v, output int c);
    c = 0;
    while ((rx ? rx_enable : key_out) !== v && c < 30000) begin
      @(posedge clock);
      #1 c++;
    end
    if (c >= 30000) begin
      fail_count++;
      close_out();
    end
  endtask
  task automatic turn(input logic [11:0] s);
    for (int i = 5; i >= 0; i--) begin
      enc_a_n <= ~s[2*i];
      enc_b_n <= ~s[2*i+1];
      repeat (20) @(posedge clock);
    end
  endtask
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      dah_in_n <= f[i];
      repeat (BIT_CYCLES) @(posedge clock);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    #1 chk({12'h0, key_out, rx_enable, tx_mute, practice_ind}, 16'h4);
    repeat (60) @(posedge clock);
    rd(REG_DOT_MS, got);
    chk(got, 16'(1200 / int'(WPM_RST)));
    rd(3'h7, got);
    chk(got, 16'h0);
    $display("reset done");
    dit_in_n <= 1'b0;
    wt(1'b0, 1'b1, n);
    chk(16'(n), 16'h2);
    chk({14'h0, rx_enable, tx_mute}, 16'h1);
    repeat (30) @(posedge clock);
    dit_in_n <= 1'b1;
    wt(1'b1, 1'b1, n);
    chk(16'(lo_n >= HOLD - 3 && lo_n <= HOLD + 3), 16'h1);
    rd(REG_STATUS, got);
    chk(16'(got[7:3]), 16'h11);
    $display("straight done");
    seed = lfsr(seed);
    wpm = 40 + int'(seed[5:0]);
    wr(REG_CTRL, {14'h0, MODE_IAMBIC});
    wr(REG_SPEED, 16'(wpm));
    repeat (40) @(posedge clock);
    rd(REG_DOT_MS, got);
    chk(got, 16'(1200 / wpm));
    dit_in_n <= 1'b0;
    wt(1'b0, 1'b1, n);
    repeat (10) @(posedge clock);
    dit_in_n <= 1'b1;
    wt(1'b1, 1'b1, n);
    chk(16'(last_run), 16'((1200 / wpm) * 20));
    wr(REG_CTRL, {14'h0, MODE_BEACON});
    wr(REG_BEACON, 16'h1);
    wt(1'b0, 1'b1, n);
    wt(1'b1, 1'b1, n);
    chk(16'(last_run), 16'(3 * (1200 / wpm) * 20));
    wr(REG_CTRL, {14'h0, MODE_STRAIGHT});
    $display("keyer done");
    for (int b = 1; b < 4; b++) begin
      btn <= 2'(b);
      repeat (30) @(posedge clock);
      btn <= BTN_NONE;
      repeat (30) @(posedge clock);
      rd(REG_STATUS, got);
      chk(16'(got[2:0]), 16'(4 + b));
    end
    turn(12'h478);
    rd(REG_ENCODER, got);
    chk(16'(got[8:0]), 16'h101);
    turn(12'h2d0);
    rd(REG_ENCODER, got);
    chk(16'(got[8:0]), 16'h0);
    $display("panel done");
    seed = lfsr(seed);
    byte_v = seed[7:0];
    send_byte(byte_v);
    rd(REG_GPS_DATA, got);
    chk(got, {8'h0, byte_v});
    dit_in_n <= 1'b0;
    repeat (10) @(posedge clock);
    #1 chk({14'h0, key_out, practice_ind}, 16'h1);
    dit_in_n <= 1'b1;
    rd(REG_STATUS, got);
    chk(16'(got[5:4]), 16'h3);
    $display("serial done");
    close_out();
  end
endmodule // tb
